//--- include/rfpc_pkg.sv
// rfpc_pkg: register map, field positions, reset words and timing for rfpc_ctrl
// assumes a 20 MHz core clock and an axi4-lite master with 32-bit data
`default_nettype none
package rfpc_pkg;
  localparam logic [3:0] AXI_ADDR_W = 4'h8;
  // register byte addresses
  localparam logic [7:0] OFS_POWER = 8'h00;
  localparam logic [7:0] OFS_FREQ = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_EVENT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // reset words
  localparam logic [15:0] RST_POWER = 16'h8208;
  localparam logic [15:0] RST_FREQ = 16'ha680;
  localparam logic [15:0] RST_RATE = 16'hc623;
  localparam logic [15:0] RST_CONFIG = 16'h8008;
  // power word field positions
  localparam int unsigned P_RX = 7;
  localparam int unsigned P_BB = 6;
  localparam int unsigned P_TX = 5;
  localparam int unsigned P_SY = 4;
  localparam int unsigned P_XO = 3;
  localparam int unsigned P_LB = 2;
  localparam int unsigned P_WK = 1;
  localparam int unsigned P_DC = 0;
  // config word field positions
  localparam int unsigned C_TXREG = 7;
  localparam int unsigned C_BAND_LO = 4;
  // event register bit positions
  localparam int unsigned E_STATRD = 0;
  localparam int unsigned E_IRQ = 1;
  // frequency range
  localparam logic [11:0] FREQ_MIN = 12'h060;
  localparam logic [11:0] FREQ_MAX = 12'hf3f;
  // clock tail length in clock-output pulses
  localparam logic [7:0] TAIL_PULSES = 8'hc0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {RFPC_OSC_OFF, RFPC_OSC_ON, RFPC_OSC_TAIL} rfpc_osc_t;
  typedef struct packed {
    logic rx_chain_en;
    logic baseband_en;
    logic tx_en;
    logic synth_en;
    logic xtal_osc_en;
    logic lowbatt_det_en;
    logic wake_timer_en;
    logic clkout_disable;
  } rfpc_pwr_t;
  typedef struct packed {
    logic xtal_on;
    logic synth_on;
    logic baseband_on;
    logic front_end_on;
    logic pa_on;
    logic tx_start;
    logic bb_cal_skip;
    logic lowbatt_on;
    logic wake_on;
    logic clkout_on;
  } rfpc_blk_t;
  typedef struct packed {
    logic aw_ok;
    logic w_ok;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rfpc_bus_t;
  typedef struct packed {
    rfpc_bus_t bus;
    logic [15:0] power;
    logic [15:0] freq;
    logic [15:0] rate;
    logic [15:0] config_w;
    logic stat_read;
    rfpc_osc_t osc;
    logic [7:0] tail_cnt;
    logic [1:0] irq_sync;
    logic clk_prev;
    logic [1:0] clk_sync;
    logic bb_was_on;
    logic freq_rej;
    rfpc_blk_t blk;
  } rfpc_state_t;
endpackage : rfpc_pkg
`default_nettype wire

//--- rtl/rfpc_ctrl.sv
// rfpc_ctrl: power-mode, frequency and bit-rate command words with oscillator control
// assumes an axi4-lite master on core_clk; irq_pending and clkout_pin are asynchronous
`default_nettype none
// Function
// RULE1: receive enable powers oscillator, synthesizer, baseband and front end
// RULE2: transmit enable powers oscillator, synthesizer, amplifier; starts sending if register on
// RULE3: receive and transmit both set means receive, never transmit
// RULE4: baseband enable alone powers baseband, pulling synthesizer and oscillator too
// RULE5: synthesizer enable powers synthesizer and oscillator
// RULE6: oscillator enable powers oscillator, under automatic and tail behaviour
// RULE7: low-battery detector and wake-up timer follow their enable bits
// RULE8: clock output disable turns off the clock output buffer
// RULE9: tail of 192 clock pulses after oscillator clear if status read came first
// RULE10: oscillator clear without status read stops clock output immediately
// RULE11: pending interrupt forces oscillator on while clock output enabled
// RULE12: all interrupts cleared plus status read turns oscillator off with tail
// RULE13: cleared oscillator enable ignored while any interrupt stays active
// RULE14: host clears power-on interrupt by status read before clearing oscillator
// RULE15: clock output disabled removes tail and interrupt oscillator control
// RULE16: baseband kept on skips calibration; receive disables amplifier, enables front end
// RULE17: frequency word accepted only within 96..3903, else old value kept
// RULE18: centre frequency is 10*C1*(C2+F/4000) MHz by band
// RULE19: bit rate is 10000/29/(R+1)/(1+7*prescale) kbps, R seven bits
// RULE20: remote rate mismatch stays under 1/(29*N) slow or 3/(29*N) fast
// RULE21: long packets keep transitions; both ends use the same divisor
// RULE22: transmit data register enabled only by its configuration bit
// RULE23: band select bits choose synthesizer band constants
// RULE24: command fields apply only once the whole 16-bit word is written
module rfpc_ctrl
  import rfpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_pending,
  input wire logic clkout_pin,
  output rfpc_blk_t blk_en,
  output logic [11:0] synth_freq_word,
  output logic [1:0] band_select,
  output logic [6:0] rate_divisor,
  output logic rate_prescale_sel
);
  rfpc_state_t st_ff;
  rfpc_state_t nxt_st;
  rfpc_pwr_t pwr;
  logic wr_go;
  logic rd_go;
  logic irq_s;
  logic clk_rise;
  logic xo_req;
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr_hit;
  logic full_word;
  logic stat_set;

  assign pwr = rfpc_pwr_t'(st_ff.power[7:0]);
  assign irq_s = st_ff.irq_sync[1];
  assign clk_rise = st_ff.clk_sync[1] & ~st_ff.clk_prev;
  assign s_axi_awready = ~st_ff.bus.aw_ok & ~st_ff.bus.bvalid;
  assign s_axi_wready = ~st_ff.bus.w_ok & ~st_ff.bus.bvalid;
  assign s_axi_arready = ~st_ff.bus.rvalid;
  assign s_axi_bvalid = st_ff.bus.bvalid;
  assign s_axi_bresp = st_ff.bus.bresp;
  assign s_axi_rvalid = st_ff.bus.rvalid;
  assign s_axi_rdata = st_ff.bus.rdata;
  assign s_axi_rresp = st_ff.bus.rresp;
  assign blk_en = st_ff.blk;
  // RULE18 word feeds synthesizer
  assign synth_freq_word = st_ff.freq[11:0];
  // RULE23 band constants
  assign band_select = st_ff.config_w[C_BAND_LO+1:C_BAND_LO];
  // RULE19 divisor fields
  assign rate_divisor = st_ff.rate[6:0];
  assign rate_prescale_sel = st_ff.rate[7];

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_POWER: rd_val = {16'h0000, st_ff.power};
      OFS_FREQ: rd_val = {16'h0000, st_ff.freq};
      OFS_RATE: rd_val = {16'h0000, st_ff.rate};
      OFS_CONFIG: rd_val = {16'h0000, st_ff.config_w};
      OFS_EVENT: rd_val = {30'h00000000, irq_s, st_ff.stat_read};
      OFS_STATUS: rd_val = {20'h00000, st_ff.freq_rej, st_ff.bb_was_on, 8'h00, st_ff.osc};
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    wr_go = 1'b0;
    rd_go = 1'b0;
    stat_set = 1'b0;
    nxt_st.irq_sync = {st_ff.irq_sync[0], irq_pending};
    nxt_st.clk_sync = {st_ff.clk_sync[0], clkout_pin};
    nxt_st.clk_prev = st_ff.clk_sync[1];
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.bus.aw_ok = 1'b1;
      nxt_st.bus.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.bus.w_ok = 1'b1;
      nxt_st.bus.wdata = s_axi_wdata;
      nxt_st.bus.wstrb = s_axi_wstrb;
    end
    if (st_ff.bus.aw_ok && st_ff.bus.w_ok) begin
      wr_go = 1'b1;
      nxt_st.bus.aw_ok = 1'b0;
      nxt_st.bus.w_ok = 1'b0;
      nxt_st.bus.bvalid = 1'b1;
    end
    if (st_ff.bus.bvalid && s_axi_bready) begin
      nxt_st.bus.bvalid = 1'b0;
    end
    // RULE24 whole word only
    full_word = &st_ff.bus.wstrb[1:0];
    wr_hit = 1'b1;
    if (wr_go) begin
      case (st_ff.bus.awaddr)
        OFS_POWER: begin
          if (full_word) nxt_st.power = {RST_POWER[15:8], st_ff.bus.wdata[7:0]};
        end
        OFS_FREQ: begin
          // RULE17 range check
          if (full_word && st_ff.bus.wdata[11:0] >= FREQ_MIN && st_ff.bus.wdata[11:0] <= FREQ_MAX) begin
            nxt_st.freq = {RST_FREQ[15:12], st_ff.bus.wdata[11:0]};
            nxt_st.freq_rej = 1'b0;
          end else if (full_word) begin
            nxt_st.freq_rej = 1'b1;
          end
        end
        OFS_RATE: begin
          if (full_word) nxt_st.rate = {RST_RATE[15:8], st_ff.bus.wdata[7:0]};
        end
        OFS_CONFIG: begin
          if (full_word) nxt_st.config_w = {RST_CONFIG[15:8], st_ff.bus.wdata[7:0]};
        end
        OFS_EVENT: begin
          // status read marker is set by a read of the event register; write one here also marks it
          if (st_ff.bus.wdata[E_STATRD]) stat_set = 1'b1;
        end
        OFS_STATUS: begin
        end
        default: wr_hit = 1'b0;
      endcase
      nxt_st.bus.bresp = (wr_hit && full_word) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd_go = 1'b1;
      nxt_st.bus.rvalid = 1'b1;
      nxt_st.bus.rdata = rd_val;
      nxt_st.bus.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      // reading the event register is the status read
      if (s_axi_araddr == OFS_EVENT) stat_set = 1'b1;
    end
    if (st_ff.bus.rvalid && s_axi_rready) begin
      nxt_st.bus.rvalid = 1'b0;
    end

    // oscillator request from enables; RULE6 explicit bit
    xo_req = pwr.xtal_osc_en;
    // RULE1 RULE2 RULE4 RULE5 dependent blocks pull the oscillator
    xo_req = xo_req | pwr.rx_chain_en | pwr.tx_en | pwr.baseband_en | pwr.synth_en;
    // RULE11 RULE13 interrupt keeps clock alive; RULE15 not with output off
    if (!pwr.clkout_disable && irq_s) xo_req = 1'b1;

    case (st_ff.osc)
      RFPC_OSC_OFF: begin
        if (xo_req) begin
          nxt_st.osc = RFPC_OSC_ON;
          nxt_st.stat_read = 1'b0;
        end
      end
      RFPC_OSC_ON: begin
        if (!xo_req) begin
          // RULE9 RULE12 tail after status read; RULE10 RULE15 immediate otherwise
          if (!pwr.clkout_disable && st_ff.stat_read) begin
            nxt_st.osc = RFPC_OSC_TAIL;
            nxt_st.tail_cnt = TAIL_PULSES;
          end else begin
            nxt_st.osc = RFPC_OSC_OFF;
          end
          nxt_st.stat_read = 1'b0;
        end
      end
      RFPC_OSC_TAIL: begin
        if (xo_req) begin
          nxt_st.osc = RFPC_OSC_ON;
        end else if (clk_rise) begin
          // RULE9 count tail pulses
          nxt_st.tail_cnt = st_ff.tail_cnt - 8'h01;
          if (st_ff.tail_cnt == 8'h01) nxt_st.osc = RFPC_OSC_OFF;
        end
      end
      default: nxt_st.osc = RFPC_OSC_OFF;
    endcase
    // a status read in the same cycle as a transition still counts: set wins
    if (stat_set) nxt_st.stat_read = 1'b1;

    nxt_st.blk.xtal_on = (nxt_st.osc != RFPC_OSC_OFF);
    // RULE5 RULE4 synthesizer needs oscillator
    nxt_st.blk.synth_on = xo_req & (pwr.synth_en | pwr.baseband_en | pwr.rx_chain_en | pwr.tx_en);
    // RULE4 RULE1 baseband
    nxt_st.blk.baseband_on = xo_req & (pwr.baseband_en | pwr.rx_chain_en);
    // RULE16 RULE1 front end in receive
    nxt_st.blk.front_end_on = pwr.rx_chain_en;
    // RULE3 RULE16 receive wins over transmit
    nxt_st.blk.pa_on = pwr.tx_en & ~pwr.rx_chain_en;
    // RULE2 RULE22 transmit start
    nxt_st.blk.tx_start = pwr.tx_en & ~pwr.rx_chain_en & st_ff.config_w[C_TXREG];
    // RULE16 calibration skipped when baseband stayed on
    nxt_st.blk.bb_cal_skip = pwr.rx_chain_en & st_ff.bb_was_on;
    nxt_st.bb_was_on = st_ff.blk.baseband_on;
    // RULE7 detector and timer
    nxt_st.blk.lowbatt_on = pwr.lowbatt_det_en;
    nxt_st.blk.wake_on = pwr.wake_timer_en;
    // RULE8 clock buffer off when disabled or oscillator stopped
    nxt_st.blk.clkout_on = ~pwr.clkout_disable & (nxt_st.osc != RFPC_OSC_OFF);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.power <= RST_POWER;
      st_ff.freq <= RST_FREQ;
      st_ff.rate <= RST_RATE;
      st_ff.config_w <= RST_CONFIG;
      st_ff.osc <= RFPC_OSC_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : rfpc_ctrl
`default_nettype wire

//--- verif/rfpc_host_model.sv
// rfpc_host_model: host side, sees the clock output and the interrupt line
// assumes clkout_on from the device; irq_req from the bench
`default_nettype none
module rfpc_host_model (
  input wire logic clkout_on,
  input wire logic irq_req,
  output logic clkout_pin,
  output logic irq_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  initial clkout_pin = 1'b0;
  // clock only while buffer on
  // phase unrelated to core_clk; pin rests low when stopped
  always #73 clkout_pin = clkout_on ? ~clkout_pin : 1'b0;
  assign irq_pending = irq_req;
endmodule : rfpc_host_model
`default_nettype wire

//--- verif/rfpc_ctrl_chk.sv
// rfpc_ctrl_chk: bus and power-control assertions on rfpc_ctrl ports
// assumes one clock domain, core_clk
`default_nettype none
module rfpc_ctrl_chk
  import rfpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rfpc_blk_t blk_en,
  input wire logic [11:0] synth_freq_word
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bad_addr: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr > OFS_STATUS |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_rx_chain: assert property (blk_en.front_end_on |-> blk_en.synth_on && blk_en.baseband_on)
    else $error("receive chain incomplete");
  a_bb_synth: assert property (blk_en.baseband_on |-> blk_en.synth_on)
    else $error("baseband without synthesizer");
  a_rx_wins: assert property (blk_en.front_end_on |-> !blk_en.pa_on && !blk_en.tx_start)
    else $error("transmit while receiving");
  a_tx_pa: assert property (blk_en.tx_start |-> blk_en.pa_on)
    else $error("send without amplifier");
  a_freq_rng: assert property (synth_freq_word >= FREQ_MIN && synth_freq_word <= FREQ_MAX)
    else $error("frequency word out of range");
  a_clk_stop: assert property ($fell(blk_en.xtal_on) |-> ##[0:1] !blk_en.clkout_on)
    else $error("clock output outlives oscillator");
  a_cal_rx: assert property (blk_en.bb_cal_skip |-> blk_en.front_end_on && blk_en.baseband_on)
    else $error("calibration skip outside receive");
  c_osc_off: cover property ($fell(blk_en.xtal_on));
  c_rx: cover property (blk_en.front_end_on);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : rfpc_ctrl_chk
bind rfpc_ctrl rfpc_ctrl_chk u_chk (.*);
`default_nettype wire

//--- verif/rfpc_ctrl_tb.sv
// rfpc_ctrl_tb: self-checking bench for rfpc_ctrl over axi4-lite
// assumes rfpc_host_model for clock output and interrupt line
`default_nettype none
module rfpc_ctrl_tb
  import rfpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq_req = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_pending, clkout_pin, rate_prescale_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp, band_select;
  rfpc_blk_t blk_en;
  logic [11:0] synth_freq_word, cur;
  logic [6:0] rate_divisor;
  int fail_count = 0, compares = 0, cycles = 0, edges = 0;
  logic [1:0] bq[$];
  logic [65:0] rq[$];
  logic [65:0] e;
  logic [7:0] pw[9] = '{8'h08, 8'h80, 8'h20, 8'ha0, 8'h40, 8'h10, 8'h0e, 8'h09, 8'h00};
  logic [11:0] fv[5] = '{12'h060, 12'h05f, 12'hf3f, 12'hf40, 12'h7d0};
  always #25 core_clk = ~core_clk;
  rfpc_ctrl u_dut (.*);
  rfpc_host_model u_host (.clkout_on(blk_en.clkout_on), .irq_req(irq_req), .clkout_pin(clkout_pin),
    .irq_pending(irq_pending));
  always @(posedge clkout_pin) edges++;
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] r);
    logic done;
    done = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d, input logic [1:0] r);
    logic done;
    done = 1'b0;
    rq.push_back({r, m, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge core_clk);
  endtask : rd
  // enables expected from the power byte, interrupt and transmit register bit
  function automatic logic [9:0] eb(input logic [7:0] p, input logic i, input logic t);
    logic x;
    x = |p[7:3] | (i & ~p[0]);
    return {x, |p[7:4], p[7] | p[6], p[7], p[5] & ~p[7], p[5] & ~p[7] & t, 1'b0, p[2], p[1], x & ~p[0]};
  endfunction : eb
  // calibration skip is masked: its timing is left to the design
  task automatic pwr(input logic [7:0] p, input logic i, input logic t);
    wr(OFS_POWER, {8'h82, p}, 4'hf, RESP_OKAY);
    cyc(4);
    chk(34'(blk_en & 10'h3f7), 34'(eb(p, i, t)));
  endtask : pwr
  task automatic tail_wait;
    for (int t = 0; t < 2000 && blk_en.xtal_on; t++) @(posedge core_clk);
    chk(34'(edges >= 191 && edges <= 195), 34'h1);
  endtask : tail_wait
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(bq.pop_front()));
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      chk({s_axi_rresp, s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]});
    end
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    void'($urandom(32'hca08319e));
    cyc(3);
    rst_n <= 1'b1;
    cyc(5);
    chk(34'({rate_prescale_sel, rate_divisor, synth_freq_word}), 34'({RST_RATE[7:0], RST_FREQ[11:0]}));
    chk(34'({band_select, blk_en & 10'h3f7}), 34'({RST_CONFIG[5:4], eb(RST_POWER[7:0], 1'b0, 1'b0)}));
    cur = RST_FREQ[11:0];
    foreach (fv[k]) begin
      if (fv[k] >= FREQ_MIN && fv[k] <= FREQ_MAX) cur = fv[k];
      wr(OFS_FREQ, {4'ha, fv[k]}, 4'hf, RESP_OKAY);
      cyc(2);
      chk(34'(synth_freq_word), 34'(cur));
      rd(OFS_STATUS, 32'h800, {20'h0, cur != fv[k], 11'h0}, RESP_OKAY);
    end
    // remote side must match this divisor; only the stored fields are checked
    repeat (4) begin
      v = 8'($urandom);
      wr(OFS_RATE, {8'hc6, v}, 4'hf, RESP_OKAY);
      cyc(2);
      chk(34'({rate_prescale_sel, rate_divisor}), 34'(v));
    end
    for (int b = 0; b < 4; b++) begin
      wr(OFS_CONFIG, {8'h80, 2'h0, 2'(b), 4'h8}, 4'hf, RESP_OKAY);
      cyc(2);
      chk(34'(band_select), 34'(b));
    end
    pwr(8'h20, 1'b0, 1'b0);
    wr(OFS_CONFIG, 16'h8098, 4'hf, RESP_OKAY);
    foreach (pw[k]) pwr(pw[k], 1'b0, 1'b1);
    pwr(8'h40, 1'b0, 1'b1);
    pwr(8'hc0, 1'b0, 1'b1);
    chk(34'(blk_en.bb_cal_skip), 34'h1);
    wr(8'h18, 16'h1234, 4'hf, RESP_SLVERR);
    rd(8'h18, 32'h0, 32'h0, RESP_SLVERR);
    wr(OFS_FREQ, 16'ha100, 4'hc, RESP_SLVERR);
    cyc(2);
    chk(34'(synth_freq_word), 34'(cur));
    pwr(8'h08, 1'b0, 1'b1);
    rd(OFS_EVENT, 32'h0, 32'h0, RESP_OKAY);
    edges = 0;
    wr(OFS_POWER, 16'h8200, 4'hf, RESP_OKAY);
    tail_wait();
    irq_req <= 1'b1;
    cyc(6);
    chk(34'(blk_en.xtal_on), 34'h1);
    pwr(8'h00, 1'b1, 1'b1);
    rd(OFS_EVENT, 32'h0, 32'h0, RESP_OKAY);
    edges = 0;
    irq_req <= 1'b0;
    tail_wait();
    pwr(8'h01, 1'b0, 1'b1);
    irq_req <= 1'b1;
    cyc(6);
    chk(34'(blk_en & 10'h3f7), 34'(eb(8'h01, 1'b1, 1'b1)));
    irq_req <= 1'b0;
    cyc(4);
    give_verdict;
  end
endmodule : rfpc_ctrl_tb
`default_nettype wire
